// ---- verilog/ccu_pkg.sv ----
// package: register map, fields, reset values and timing of the clock control unit
package ccu_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] CCU_ADDR_DIVIDE_CONTROL = 8'h61;
   localparam logic [7:0] CCU_ADDR_OSC_TRIM = 8'h66;
   localparam logic [7:0] CCU_ADDR_SLEEP_CONTROL = 8'h53;
   localparam logic [7:0] CCU_ADDR_SLEEP_STATUS = 8'h54;
   // ==========================================
   // field positions
   localparam int CCU_DIV_CE_BIT = 7;
   localparam int CCU_TRIM_RANGE_BIT = 7;
   localparam int CCU_SLEEP_EN_BIT = 0;
   localparam int CCU_SLEEP_MODE_LSB = 1;
   // ==========================================
   // reset values and largest divider code
   localparam logic [3:0] CCU_DIV_RESET_NORMAL = 4'h0;
   localparam logic [3:0] CCU_DIV_RESET_FUSED = 4'h3;
   localparam logic [3:0] CCU_DIV_MAX_CODE = 4'h8;
   localparam logic [7:0] CCU_TRIM_DEFAULT = 8'h80;
   // ==========================================
   // timing
   localparam logic [2:0] CCU_UNLOCK_CYCLES = 3'd4;
   localparam logic [2:0] CCU_WAKE_HALT_CYCLES = 3'd4;
   localparam logic [3:0] CCU_STANDBY_START_CYCLES = 4'd6;
   // ==========================================
   // sleep mode codes
   localparam logic [2:0] CCU_SM_IDLE = 3'b000;
   localparam logic [2:0] CCU_SM_NOISE = 3'b001;
   localparam logic [2:0] CCU_SM_PDOWN = 3'b010;
   localparam logic [2:0] CCU_SM_PSAVE = 3'b011;
   localparam logic [2:0] CCU_SM_STANDBY = 3'b110;
   // wake source bit order
   localparam int CCU_WK_EXT = 0;
   localparam int CCU_WK_START = 1;
   localparam int CCU_WK_TIMER2 = 2;
   localparam int CCU_WK_MEMRDY = 3;
   localparam int CCU_WK_CONV = 4;
   localparam int CCU_WK_OTHER = 5;
   localparam int CCU_WK_COUNT = 6;

   typedef enum logic [3:0] {
      CCU_RUN = 4'b0001,
      CCU_SLEEP = 4'b0010,
      CCU_START = 4'b0100,
      CCU_HALT = 4'b1000
   } ccu_state_e;
endpackage

// ---- verilog/ccu_clock_control.sv ----
// clock control unit: oscillator trim, guarded system clock divider, sleep gating
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module ccu_clock_control #(
   parameter logic [7:0] FACTORY_TRIM = ccu_pkg::CCU_TRIM_DEFAULT,
   parameter int START_CYCLES = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // straps and core
   input wire logic div_by_eight_fuse,
   input wire logic crystal_selected,
   input wire logic sleep_instr,
   input wire logic timer2_async,
   input wire logic external_irq_zero_level,
   input wire logic [ccu_pkg::CCU_WK_COUNT-1:0] wake_req,
   // oscillator, clock enables, halt and wake status
   output logic [7:0] trim_value,
   output logic div_tick,
   output logic cpu_domain_clock_en,
   output logic flash_domain_clock_en,
   output logic io_domain_clock_en,
   output logic converter_domain_clock_en,
   output logic async_domain_clock_en,
   output logic main_osc_en,
   output logic timer_osc_en,
   output logic core_halted,
   output logic wake_event
);
   import ccu_pkg::*;

   // wait counter is sixteen bits: larger start-up counts cannot be served
   if (START_CYCLES < 1 || START_CYCLES > 65535) begin : g_bad_start
      $error("START_CYCLES out of range");
   end

   localparam logic [15:0] START_LEN = START_CYCLES[15:0];

   // ==========================================
   // input synchronisers
   logic [CCU_WK_COUNT-1:0] wake_meta;
   logic [CCU_WK_COUNT-1:0] wake_sync;
   logic lvl_meta;
   logic lvl_sync;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_meta <= '0;
         wake_sync <= '0;
         lvl_meta <= 1'b0;
         lvl_sync <= 1'b0;
      end else begin
         wake_meta <= wake_req;
         wake_sync <= wake_meta;
         lvl_meta <= external_irq_zero_level;
         lvl_sync <= lvl_meta;
      end
   end

   // ==========================================
   // register decode
   logic wr_div;
   logic wr_trim;
   logic wr_sleep;
   assign wr_div = reg_wr && (reg_addr == CCU_ADDR_DIVIDE_CONTROL);
   assign wr_trim = reg_wr && (reg_addr == CCU_ADDR_OSC_TRIM);
   assign wr_sleep = reg_wr && (reg_addr == CCU_ADDR_SLEEP_CONTROL);

   // ==========================================
   // oscillator trim
   // factory value at reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trim_value <= FACTORY_TRIM;
      end else if (wr_trim) begin
         // bit 7 range, bits 6..0 fine, passed straight to oscillator
         trim_value <= reg_wdata;
      end
   end

   // ==========================================
   // divider unlock window
   logic change_enable;
   logic [2:0] ce_count;
   logic [3:0] divider_select;
   logic ce_write;
   logic sel_write;
   // only a write with all other bits zero arms the enable
   assign ce_write = wr_div && reg_wdata[CCU_DIV_CE_BIT] && (reg_wdata[6:0] == 7'h00);
   assign sel_write = wr_div && !reg_wdata[CCU_DIV_CE_BIT];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         change_enable <= 1'b0;
         ce_count <= 3'd0;
      end else if (change_enable) begin
         if (sel_write || ce_count == CCU_UNLOCK_CYCLES - 3'd1) begin
            change_enable <= 1'b0;
            ce_count <= 3'd0;
         end else begin
            ce_count <= ce_count + 3'd1;
         end
      end else if (ce_write) begin
         change_enable <= 1'b1;
         ce_count <= 3'd0;
      end
   end

   // fuse is a strap: sampled only by this clocked reset branch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divider_select <= div_by_eight_fuse ? CCU_DIV_RESET_FUSED : CCU_DIV_RESET_NORMAL;
      end else if (sel_write && change_enable) begin
         divider_select <= reg_wdata[3:0];
      end
   end

   // ==========================================
   // divider
   // factor two to the select; reserved codes treated as largest
   function automatic logic [7:0] div_mask(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > CCU_DIV_MAX_CODE) ? CCU_DIV_MAX_CODE : sel;
      div_mask = 8'(9'h001 << s) - 8'h01;
      if (s == CCU_DIV_MAX_CODE) begin
         div_mask = 8'hFF;
      end
   endfunction

   logic [7:0] div_count;
   logic [7:0] cur_mask;
   logic [7:0] pend_mask;
   logic pend;
   logic tick_now;
   assign tick_now = (div_count & cur_mask) == cur_mask;

   // new factor applied only at a period end, so no short pulse or faster edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur_mask <= 8'h00;
         pend <= 1'b0;
         pend_mask <= 8'h00;
      end else begin
         if (sel_write && change_enable) begin
            pend <= 1'b1;
            pend_mask <= div_mask(reg_wdata[3:0]);
         end else if (pend && tick_now) begin
            pend <= 1'b0;
            cur_mask <= pend_mask;
         end else if (!pend) begin
            cur_mask <= div_mask(divider_select);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_count <= 8'h00;
      end else if (tick_now) begin
         div_count <= 8'h00;
      end else begin
         div_count <= div_count + 8'h01;
      end
   end

   // one tick enables every synchronous domain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_tick <= 1'b0;
      end else begin
         div_tick <= tick_now;
      end
   end

   // ==========================================
   // sleep control register
   logic sleep_enable;
   logic [2:0] sleep_mode_select;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sleep_enable <= 1'b0;
         sleep_mode_select <= CCU_SM_IDLE;
      end else if (wr_sleep) begin
         sleep_enable <= reg_wdata[CCU_SLEEP_EN_BIT];
         sleep_mode_select <= reg_wdata[CCU_SLEEP_MODE_LSB +: 3];
      end
   end

   // ==========================================
   // sleep state machine
   ccu_state_e state;
   logic [2:0] active_mode;
   logic [15:0] wait_count;
   logic [CCU_WK_COUNT-1:0] allowed;
   logic wake_hit;
   logic valid_mode;

   assign valid_mode = (sleep_mode_select == CCU_SM_IDLE) || (sleep_mode_select == CCU_SM_NOISE)
      || (sleep_mode_select == CCU_SM_PDOWN) || (sleep_mode_select == CCU_SM_PSAVE)
      || (sleep_mode_select == CCU_SM_STANDBY && crystal_selected);

   always_comb begin
      allowed = '0;
      unique case (active_mode)
         CCU_SM_IDLE: allowed = '1;
         CCU_SM_NOISE: begin
            allowed[CCU_WK_EXT] = 1'b1;
            allowed[CCU_WK_START] = 1'b1;
            allowed[CCU_WK_TIMER2] = timer2_async;
            allowed[CCU_WK_MEMRDY] = 1'b1;
            allowed[CCU_WK_CONV] = 1'b1;
         end
         CCU_SM_PSAVE: begin
            allowed[CCU_WK_EXT] = 1'b1;
            allowed[CCU_WK_START] = 1'b1;
            allowed[CCU_WK_TIMER2] = timer2_async;
         end
         default: begin
            allowed[CCU_WK_EXT] = 1'b1;
            allowed[CCU_WK_START] = 1'b1;
         end
      endcase
      // beyond idle, irq zero only as level
      if (active_mode != CCU_SM_IDLE && !lvl_sync) begin
         allowed[CCU_WK_EXT] = 1'b0;
      end
   end
   assign wake_hit = |(wake_sync & allowed);

   // synchronous reset forces run state from any sleep
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= CCU_RUN;
         active_mode <= CCU_SM_IDLE;
         wait_count <= 16'd0;
      end else begin
         unique case (state)
            CCU_RUN: begin
               // enable bit and instruction both needed
               if (sleep_instr && sleep_enable && valid_mode) begin
                  state <= CCU_SLEEP;
                  active_mode <= sleep_mode_select;
               end
            end
            CCU_SLEEP: begin
               if (wake_hit) begin
                  wait_count <= 16'd0;
                  if (active_mode == CCU_SM_IDLE || active_mode == CCU_SM_NOISE) begin
                     state <= CCU_HALT;
                  end else begin
                     state <= CCU_START;
                  end
               end
            end
            CCU_START: begin
               // standby restarts in six cycles; oscillator kept running
               if ((active_mode == CCU_SM_STANDBY &&
                    wait_count == {12'd0, CCU_STANDBY_START_CYCLES} - 16'd1) ||
                   (active_mode != CCU_SM_STANDBY && wait_count == START_LEN - 16'd1)) begin
                  state <= CCU_HALT;
                  wait_count <= 16'd0;
               end else begin
                  wait_count <= wait_count + 16'd1;
               end
            end
            CCU_HALT: begin
               if (wait_count == {13'd0, CCU_WAKE_HALT_CYCLES} - 16'd1) begin
                  state <= CCU_RUN;
                  wait_count <= 16'd0;
               end else begin
                  wait_count <= wait_count + 16'd1;
               end
            end
         endcase
      end
   end

   // ==========================================
   // gating outputs
   logic sleeping;
   assign sleeping = (state == CCU_SLEEP);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cpu_domain_clock_en <= 1'b1;
         flash_domain_clock_en <= 1'b1;
         io_domain_clock_en <= 1'b1;
         converter_domain_clock_en <= 1'b1;
         async_domain_clock_en <= 1'b1;
         main_osc_en <= 1'b1;
         timer_osc_en <= 1'b0;
         core_halted <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         cpu_domain_clock_en <= (state == CCU_RUN);
         flash_domain_clock_en <= (state == CCU_RUN);
         io_domain_clock_en <= !sleeping || active_mode == CCU_SM_IDLE;
         converter_domain_clock_en <= !sleeping || active_mode == CCU_SM_IDLE
            || active_mode == CCU_SM_NOISE;
         async_domain_clock_en <= !sleeping || active_mode == CCU_SM_IDLE
            || active_mode == CCU_SM_NOISE || active_mode == CCU_SM_PSAVE;
         main_osc_en <= !sleeping || active_mode == CCU_SM_IDLE
            || active_mode == CCU_SM_NOISE || active_mode == CCU_SM_STANDBY;
         timer_osc_en <= timer2_async && (!sleeping || active_mode == CCU_SM_IDLE
            || active_mode == CCU_SM_NOISE || active_mode == CCU_SM_PSAVE);
         core_halted <= (state != CCU_RUN);
         wake_event <= sleeping && wake_hit;
      end
   end

   // ==========================================
   // read port, unmapped reads zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            CCU_ADDR_DIVIDE_CONTROL: reg_rdata <= {change_enable, 3'b000, divider_select};
            CCU_ADDR_OSC_TRIM: reg_rdata <= trim_value;
            CCU_ADDR_SLEEP_CONTROL: reg_rdata <= {4'h0, sleep_mode_select, sleep_enable};
            CCU_ADDR_SLEEP_STATUS: reg_rdata <= {4'h0, state};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ---- verif/ccu_clock_control_assertions.sv ----
// checker: port-level timing relations of the clock control unit
`timescale 1ns/1ps
module ccu_chk (
   // unit inputs
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic sleep_instr,
   input wire logic timer2_async,
   // unit outputs
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] trim_value,
   input wire logic cpu_domain_clock_en,
   input wire logic flash_domain_clock_en,
   input wire logic io_domain_clock_en,
   input wire logic converter_domain_clock_en,
   input wire logic async_domain_clock_en,
   input wire logic timer_osc_en,
   input wire logic core_halted,
   input wire logic wake_event
);
   import ccu_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ==========
   // assertions
   chk_trim_write: assert property (
      reg_wr && reg_addr == CCU_ADDR_OSC_TRIM |=> trim_value == $past(reg_wdata))
      else $error("trim output missed a write");
   chk_div_reserved: assert property (
      reg_rd && reg_addr == CCU_ADDR_DIVIDE_CONTROL |=> reg_rdata[6:4] == 3'b000)
      else $error("divider bits six to four not zero");
   chk_cpu_flash_pair: assert property (
      cpu_domain_clock_en == flash_domain_clock_en)
      else $error("cpu and flash enables differ");
   chk_io_needs_conv: assert property (
      io_domain_clock_en |-> converter_domain_clock_en && async_domain_clock_en)
      else $error("io runs without converter or async");
   chk_cpu_needs_io: assert property (
      cpu_domain_clock_en |-> io_domain_clock_en)
      else $error("cpu runs without io");
   chk_wake_halt: assert property (
      $rose(wake_event) |-> core_halted [*4])
      else $error("core released too early after wake");
   chk_wake_asleep: assert property (
      wake_event |-> core_halted)
      else $error("wake event while running");
   chk_sleep_cause: assert property (
      $rose(core_halted) |-> $past(sleep_instr) || $past(sleep_instr, 2))
      else $error("halt without sleep instruction");
   chk_timer_osc: assert property (
      timer_osc_en |-> $past(timer2_async))
      else $error("timer oscillator on while timer2 synchronous");
endmodule

// ---- verif/tb_ccu_clock_control.sv ----
// testbench: reset, trim, divider unlock and sleep scenarios for the clock control unit
`timescale 1ns/1ps
module tb_ccu_clock_control;
   import ccu_pkg::*;
   localparam logic [7:0] DIV = CCU_ADDR_DIVIDE_CONTROL;
   logic clk, rst_n, reg_wr, reg_rd, fuse, xtal, sleep_instr, t2a, lvl;
   logic div_tick, cpu_en, fl_en, io_en, cv_en, as_en, mo_en, to_en, halted, wake_event;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, trim_value, v;
   logic [5:0] wake_req, en;
   logic [3:0] c;
   logic [2:0] modes [5] = '{CCU_SM_IDLE, CCU_SM_NOISE, CCU_SM_PDOWN, CCU_SM_PSAVE, CCU_SM_STANDBY};
   int fail_count = 0;
   int compares = 0;
   int i, n;
   assign en = {cpu_en, fl_en, io_en, cv_en, as_en, mo_en};
   // short start-up count keeps wake scenarios brief
   ccu_clock_control #(.FACTORY_TRIM(8'h3C), .START_CYCLES(2)) DUT (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .div_by_eight_fuse(fuse),
      .crystal_selected(xtal), .sleep_instr(sleep_instr), .timer2_async(t2a),
      .external_irq_zero_level(lvl), .wake_req(wake_req), .trim_value(trim_value),
      .div_tick(div_tick), .cpu_domain_clock_en(cpu_en), .flash_domain_clock_en(fl_en),
      .io_domain_clock_en(io_en), .converter_domain_clock_en(cv_en),
      .async_domain_clock_en(as_en), .main_osc_en(mo_en), .timer_osc_en(to_en),
      .core_halted(halted), .wake_event(wake_event));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic limit(input int k, input int lim);
      if (k >= lim) begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask
   task automatic nop();
      bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   // data stands only in the cycle after the strobe; looked at mid-cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      reg_rd <= 1'b0;
      @(negedge clk);
      check(reg_rdata, exp);
      @(posedge clk);
   endtask
   task automatic reset(input logic f);
      rst_n <= 1'b0;
      fuse <= f;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic tick_gap(output int g);
      int k;
      for (k = 0; k < 600 && div_tick !== 1'b1; k++) @(posedge clk);
      limit(k, 600);
      @(posedge clk);
      for (g = 1; g < 600 && div_tick !== 1'b1; g++) @(posedge clk);
      limit(g, 600);
   endtask
   // expected {cpu, flash, io, converter, async, main osc} while asleep
   function automatic logic [5:0] gates(input logic [2:0] m);
      case (m)
         CCU_SM_IDLE: return 6'h0F;
         CCU_SM_NOISE: return 6'h07;
         CCU_SM_PSAVE: return 6'h02;
         CCU_SM_STANDBY: return 6'h01;
         default: return 6'h00;
      endcase
   endfunction
   // bit0 beyond idle only counts as a level irq
   function automatic logic [5:0] wakes(input logic [2:0] m);
      case (m)
         CCU_SM_IDLE: return 6'h3F;
         CCU_SM_NOISE: return {3'b011, t2a, 1'b1, lvl};
         CCU_SM_PSAVE: return {3'b000, t2a, 1'b1, lvl};
         default: return {4'h0, 1'b1, lvl};
      endcase
   endfunction
   task automatic enter(input logic [2:0] m, input logic se);
      bus(1'b1, 1'b0, CCU_ADDR_SLEEP_CONTROL, {4'h0, m, se});
      sleep_instr <= 1'b1;
      nop();
      sleep_instr <= 1'b0;
      repeat (3) nop();
   endtask
   task automatic nap(input logic [2:0] m);
      logic [5:0] ok;
      int k;
      int w;
      enter(m, 1'b1);
      ok = wakes(m);
      check(halted, 1'b1);
      check(en, gates(m));
      check(to_en, t2a && m != CCU_SM_PDOWN && m != CCU_SM_STANDBY);
      wake_req <= ~ok;
      rd(CCU_ADDR_SLEEP_STATUS, 8'h02);
      rd(CCU_ADDR_SLEEP_CONTROL, {4'h0, m, 1'b1});
      repeat (4) nop();
      check(halted, 1'b1);
      wake_req <= ok & (6'($urandom) | 6'h02);
      for (k = 0; k < 60 && wake_event !== 1'b1; k++) nop();
      limit(k, 60);
      wake_req <= 6'h00;
      for (w = 0; w < 60 && halted !== 1'b0; w++) nop();
      limit(w, 60);
      k = (m == CCU_SM_IDLE || m == CCU_SM_NOISE) ? 4 : (m == CCU_SM_STANDBY) ? 10 : 6;
      check(w >= k, 1'b1);
   endtask
   // ==========
   // main sequence
   initial begin
      void'($urandom(32'hff2c0bac));
      rst_n = 1'b0;
      {reg_wr, reg_rd, sleep_instr, fuse, t2a, lvl} = 6'h00;
      xtal = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      wake_req = 6'h00;
      reset(1'b0);
      check(trim_value, 8'h3C);
      rd(DIV, 8'h00);
      reset(1'b1);
      rd(DIV, 8'h03);
      bus(1'b1, 1'b0, 8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      // no nvm writes here, any trim legal
      for (i = 0; i < 5; i++) begin
         v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
         bus(1'b1, 1'b0, CCU_ADDR_OSC_TRIM, v);
         rd(CCU_ADDR_OSC_TRIM, v);
         check(trim_value, v);
      end
      bus(1'b1, 1'b0, DIV, 8'h80);
      bus(1'b1, 1'b0, DIV, 8'h05);
      rd(DIV, 8'h05);
      bus(1'b1, 1'b0, DIV, 8'h80);
      rd(DIV, 8'h85);
      repeat (2) nop();
      bus(1'b1, 1'b0, DIV, 8'h02);
      rd(DIV, 8'h05);
      bus(1'b1, 1'b0, DIV, 8'h80);
      repeat (2) nop();
      bus(1'b1, 1'b0, DIV, 8'h80);
      nop();
      bus(1'b1, 1'b0, DIV, 8'h02);
      rd(DIV, 8'h05);
      bus(1'b1, 1'b0, DIV, 8'h8F);
      bus(1'b1, 1'b0, DIV, 8'h02);
      rd(DIV, 8'h05);
      bus(1'b1, 1'b0, DIV, 8'h80);
      bus(1'b1, 1'b0, DIV, 8'h76);
      bus(1'b1, 1'b0, DIV, 8'h02);
      rd(DIV, 8'h06);
      for (i = 0; i < 10; i++) begin
         t2a <= 1'($urandom);
         lvl <= 1'($urandom);
         nap(modes[i % 5]);
      end
      enter(CCU_SM_IDLE, 1'b0);
      check(halted, 1'b0);
      xtal <= 1'b0;
      enter(CCU_SM_STANDBY, 1'b1);
      check(halted, 1'b0);
      xtal <= 1'b1;
      enter(CCU_SM_PDOWN, 1'b1);
      check(halted, 1'b1);
      reset(1'b0);
      check(halted, 1'b0);
      check(en, 6'h3F);
      rd(CCU_ADDR_SLEEP_STATUS, 8'h01);
      for (i = 0; i < 10; i++) begin
         c = (i < 9) ? 4'(i) : 4'(9 + $urandom % 7);
         bus(1'b1, 1'b0, DIV, 8'h80);
         repeat (3) nop();
         bus(1'b1, 1'b0, DIV, {4'h0, c});
         rd(DIV, {4'h0, c});
         tick_gap(n);
         tick_gap(n);
         check(16'(n), 16'h1 << ((c > 4'h8) ? 4'h8 : c));
      end
      print_verdict();
   end
endmodule
bind ccu_clock_control ccu_chk u_chk (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .sleep_instr(sleep_instr),
   .timer2_async(timer2_async), .reg_rdata(reg_rdata), .trim_value(trim_value),
   .cpu_domain_clock_en(cpu_domain_clock_en), .flash_domain_clock_en(flash_domain_clock_en),
   .io_domain_clock_en(io_domain_clock_en),
   .converter_domain_clock_en(converter_domain_clock_en),
   .async_domain_clock_en(async_domain_clock_en), .timer_osc_en(timer_osc_en),
   .core_halted(core_halted), .wake_event(wake_event));
